// file: core/asc_adc_sequence_control.sv
/*
 * conversion sequencer and register file of the eight-input converter.
 * assumes an avalon-mm master and an analog core that returns a 10-bit
 * value with a one-cycle done pulse some cycles after each start pulse.
 */
// Chosen here: the Avalon-MM register port.
// Functional notes
// - any control write clears flags; with power-up set it also aborts and starts a new sequence
// - length bit 0 gives four conversions, 1 gives eight, captured at write
// - scan bit 0 runs once and halts, 1 repeats until rewritten or aborted
// - multichannel 0 converts one input selected by all four select bits
// - multichannel 1 steps through group chosen by upper select bits
// - four-mode groups: 0-3, 4-7, reserved, references; result index low bits
// - eight-mode: top bit 0 inputs 0-7, top bit 1 references in slots 4-7
// - complete flag set at end of single sequence or first scan sequence
// - complete flag cleared by control write, or first result read if fast
// - 3-bit counter shows sequence position and next result register
// - each completion flag sets when its result register is loaded
// - fast clear clears on read; otherwise status read must come first
// - status always readable; flags writable only in special mode
// - test register only in special mode; else reads zero, writes ignored
// - approximation field reads live value, writable in special mode
// - module soft reset restores power-on state except power-up bit
// - four test-select bits pick one of 16 factory test modes
// - digital port returns pin levels; writes ignored
// - results unsigned left-justified over two bytes, read-only, no reset
// - fast-clear bit picks status-then-result or any-access clearing
// - resolution bit selects 8-bit or 10-bit conversions
// - clearing power-up aborts sequence; registers stay accessible
module asc_adc_sequence_control (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // mode strap
    input wire logic special_mode_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // analog core
    output asc_pkg::asc_core_req_t core_req_o,
    input wire logic core_done_i,
    input wire logic [9:0] core_value_i,
    output logic [9:0] approximation_value_o,
    output logic test_output_mux_o,
    output logic [3:0] factory_test_select_o,
    // pins
    input wire logic [7:0] digital_pin_levels_i
);

    // ****************************************************************
    // sizes
    // ****************************************************************
    // eight result slots; the counter is just wide enough to index them
    localparam int NUM_RESULTS = 8;
    localparam int CNT_W = 3;

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] ctrl_q;
    logic [2:0] cfg_q;
    logic [3:0] tsel_q;
    logic tout_q;
    logic scf_q;
    logic first_seq_q;
    logic [CNT_W-1:0] cnt_q;
    logic [9:0] sar_q;
    // no reset on results: a slot holds junk until its first conversion
    logic [15:0] result_q [NUM_RESULTS];
    asc_pkg::asc_state_t state_q;
    asc_pkg::asc_core_req_t core_req_q;
    logic wait_q;
    logic [31:0] rdata_q;

    // ****************************************************************
    // combinational helpers
    // ****************************************************************
    logic [NUM_RESULTS-1:0] ccf_w;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_test;
    logic hit_port;
    logic hit_cfg;
    logic hit_res;
    logic [CNT_W-1:0] res_idx;
    logic take;
    logic fire_rd;
    logic fire_wr;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_stat;
    logic wr_test;
    logic soft_rst;
    logic clr;
    logic rd_stat;
    logic res_touch;
    logic pu;
    logic fast;
    logic scan;
    logic go;
    logic halt;
    logic seq_store;
    logic last_conv;
    logic [CNT_W-1:0] last_idx;
    logic [CNT_W-1:0] cnt_next;
    logic [15:0] fmt_value;
    logic [31:0] rd_mux;

    // ****************************************************************
    // channel for one slot of the sequence
    // ****************************************************************
    // the slot index is also the result register index in every mode
    function automatic logic [3:0] chan_of(input logic [7:0] ctrl,
                                           input logic [CNT_W-1:0] idx);
        logic [3:0] chan;
        chan = ctrl[3:0];
        if (ctrl[asc_pkg::CTL_MULTICHANNEL_ENABLE_BIT]) begin
            if (ctrl[asc_pkg::CTL_S8_BIT]) begin
                // top select bit picks inputs or the reference block
                chan = {ctrl[3], idx};
            end else begin
                // group of four from the two upper select bits
                chan = {ctrl[3:2], idx[1:0]};
            end
        end
        return chan;
    endfunction

    // ****************************************************************
    // address decode
    // ****************************************************************
    assign hit_ctrl = avs_address_i == asc_pkg::SEQ_CTRL_OFS;
    assign hit_stat = avs_address_i == asc_pkg::STATUS_OFS;
    assign hit_test = avs_address_i == asc_pkg::TEST_OFS;
    assign hit_port = avs_address_i == asc_pkg::PORT_OFS;
    assign hit_cfg = avs_address_i == asc_pkg::CONFIG_OFS;
    // eight word slots above the result base
    assign hit_res = (avs_address_i[7:5] == asc_pkg::RESULT_OFS[7:5])
        && (avs_address_i[1:0] == 2'h0);
    assign res_idx = avs_address_i[4:2];

    // ****************************************************************
    // bus handshake
    // ****************************************************************
    // first cycle latches read data, second cycle answers
    assign take = (avs_read_i || avs_write_i) && wait_q;
    assign fire_rd = avs_read_i && !wait_q;
    assign fire_wr = avs_write_i && !wait_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !take;
        end
    end

    // ****************************************************************
    // register events
    // ****************************************************************
    assign wr_ctrl = fire_wr && hit_ctrl && avs_byteenable_i[0];
    assign wr_cfg = fire_wr && hit_cfg && avs_byteenable_i[0];
    assign wr_stat = fire_wr && hit_stat && special_mode_i
        && (&avs_byteenable_i[1:0]);
    assign wr_test = fire_wr && hit_test && special_mode_i
        && (&avs_byteenable_i[1:0]);
    assign soft_rst = wr_test && avs_writedata_i[asc_pkg::TEST_RST_BIT];
    // soft reset clears the block but not the bus handshake
    assign clr = rst_i || soft_rst;
    assign rd_stat = fire_rd && hit_stat;
    // with fast clear any access to a slot counts, else reads only
    assign res_touch = hit_res && (fire_rd || (fire_wr && fast));

    // ****************************************************************
    // mode bits
    // ****************************************************************
    assign pu = cfg_q[asc_pkg::CFG_PU_BIT];
    assign fast = cfg_q[asc_pkg::CFG_FFC_BIT];
    assign scan = ctrl_q[asc_pkg::CTL_SCAN_BIT];
    assign last_idx = ctrl_q[asc_pkg::CTL_S8_BIT] ? 3'h7 : 3'h3;
    assign last_conv = cnt_q == last_idx;
    assign cnt_next = CNT_W'(cnt_q + 3'h1);
    // a powered-down converter takes the write but starts nothing
    assign go = wr_ctrl && pu;
    assign halt = wr_cfg && !avs_writedata_i[asc_pkg::CFG_PU_BIT];
    // an abort in the same cycle wins over a pending store
    assign seq_store = (state_q == asc_pkg::ASC_STORE) && !wr_ctrl && !halt && pu;

    // ****************************************************************
    // control and configuration registers
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            ctrl_q <= asc_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= avs_writedata_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cfg_q <= asc_pkg::CFG_RST;
        end else if (soft_rst) begin
            // power-up survives the module soft reset
            cfg_q <= asc_pkg::CFG_RST;
            cfg_q[asc_pkg::CFG_PU_BIT] <= cfg_q[asc_pkg::CFG_PU_BIT];
        end else if (wr_cfg) begin
            cfg_q <= avs_writedata_i[2:0];
        end
    end

    // ****************************************************************
    // factory test bits
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            tout_q <= 1'b0;
            tsel_q <= 4'h0;
        end else if (wr_test) begin
            tout_q <= avs_writedata_i[asc_pkg::TEST_OUT_BIT];
            tsel_q <= avs_writedata_i[asc_pkg::TEST_SEL_LSB +: 4];
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            state_q <= asc_pkg::ASC_IDLE;
            cnt_q <= '0;
            first_seq_q <= 1'b0;
            core_req_q <= '0;
        end else begin
            core_req_q.start <= 1'b0;
            if (go) begin
                // abort whatever runs and restart from slot zero
                state_q <= asc_pkg::ASC_CONV;
                cnt_q <= '0;
                first_seq_q <= 1'b1;
                core_req_q.start <= 1'b1;
                core_req_q.chan <= chan_of(avs_writedata_i[7:0], 3'h0);
                core_req_q.ten_bit <= cfg_q[asc_pkg::CFG_10B_BIT];
            end else if (halt || !pu) begin
                state_q <= asc_pkg::ASC_IDLE;
            end else begin
                unique case (state_q)
                    asc_pkg::ASC_IDLE: begin
                        state_q <= asc_pkg::ASC_IDLE;
                    end
                    asc_pkg::ASC_CONV: begin
                        if (core_done_i) begin
                            state_q <= asc_pkg::ASC_STORE;
                        end
                    end
                    asc_pkg::ASC_STORE: begin
                        core_req_q.ten_bit <= cfg_q[asc_pkg::CFG_10B_BIT];
                        if (last_conv) begin
                            cnt_q <= '0;
                            first_seq_q <= 1'b0;
                            if (scan) begin
                                state_q <= asc_pkg::ASC_CONV;
                                core_req_q.start <= 1'b1;
                                core_req_q.chan <= chan_of(ctrl_q, 3'h0);
                            end else begin
                                state_q <= asc_pkg::ASC_IDLE;
                            end
                        end else begin
                            cnt_q <= cnt_next;
                            state_q <= asc_pkg::ASC_CONV;
                            core_req_q.start <= 1'b1;
                            core_req_q.chan <= chan_of(ctrl_q, cnt_next);
                        end
                    end
                    default: begin
                        state_q <= asc_pkg::ASC_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // approximation value
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            sar_q <= asc_pkg::SAR_RST;
        end else if (wr_test) begin
            sar_q <= avs_writedata_i[9:0];
        end else if (state_q == asc_pkg::ASC_CONV && core_done_i) begin
            sar_q <= core_value_i;
        end
    end

    // ****************************************************************
    // results
    // ****************************************************************
    // left-justified; 8-bit results leave the low byte at zero
    always_comb begin
        if (core_req_q.ten_bit) begin
            fmt_value = {sar_q, 6'h00};
        end else begin
            fmt_value = {sar_q[9:2], 8'h00};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (seq_store) begin
            result_q[cnt_q] <= fmt_value;
        end
    end

    // ****************************************************************
    // sequence complete flag
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            scf_q <= 1'b0;
        end else if (seq_store && last_conv && first_seq_q) begin
            // scan mode sets it after the first pass only
            scf_q <= 1'b1;
        end else if (wr_ctrl) begin
            scf_q <= 1'b0;
        end else if (wr_stat) begin
            scf_q <= avs_writedata_i[asc_pkg::STAT_SCF_BIT];
        end else if (fast && res_touch && res_idx == 3'h0) begin
            scf_q <= 1'b0;
        end
    end

    // ****************************************************************
    // completion flags, one per result slot
    // ****************************************************************
    // a status read arms only the flags already set at that time,
    // so a result landing afterwards still needs its own status read
    for (genvar i = 0; i < NUM_RESULTS; i++) begin : g_flag
        logic ccf_bit_q;
        logic armed_q;
        logic hit_me;
        assign hit_me = res_touch && (res_idx == CNT_W'(i));
        assign ccf_w[i] = ccf_bit_q;

        always_ff @(posedge clk_sys_i) begin
            if (clr) begin
                ccf_bit_q <= 1'b0;
            end else if (seq_store && cnt_q == CNT_W'(i)) begin
                ccf_bit_q <= 1'b1;
            end else if (wr_ctrl) begin
                ccf_bit_q <= 1'b0;
            end else if (wr_stat) begin
                ccf_bit_q <= avs_writedata_i[i];
            end else if (hit_me && (fast || armed_q)) begin
                ccf_bit_q <= 1'b0;
            end
        end

        always_ff @(posedge clk_sys_i) begin
            if (clr) begin
                armed_q <= 1'b0;
            end else if (wr_ctrl || hit_me) begin
                armed_q <= 1'b0;
            end else if (rd_stat) begin
                armed_q <= ccf_bit_q;
            end
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    always_comb begin
        rd_mux = '0;
        if (hit_ctrl) begin
            rd_mux[7:0] = ctrl_q;
        end else if (hit_stat) begin
            rd_mux[asc_pkg::STAT_SCF_BIT] = scf_q;
            rd_mux[asc_pkg::STAT_CNT_LSB +: CNT_W] = cnt_q;
            rd_mux[7:0] = ccf_w;
        end else if (hit_test && special_mode_i) begin
            // normal mode reads the test word as zero
            rd_mux[9:0] = sar_q;
            rd_mux[asc_pkg::TEST_OUT_BIT] = tout_q;
            rd_mux[asc_pkg::TEST_SEL_LSB +: 4] = tsel_q;
        end else if (hit_port) begin
            rd_mux[7:0] = digital_pin_levels_i;
        end else if (hit_cfg) begin
            rd_mux[2:0] = cfg_q;
        end else if (hit_res) begin
            rd_mux[15:0] = result_q[res_idx];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (take) begin
            rdata_q <= rd_mux;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign core_req_o = core_req_q;
    assign approximation_value_o = sar_q;
    assign test_output_mux_o = tout_q;
    assign factory_test_select_o = tsel_q;
endmodule // asc_adc_sequence_control

// file: pkg/asc_pkg.sv
/*
 * package for the conversion sequencer: register map, field positions,
 * reset values, timing counts, the state enum and the struct that carries the analog core link.
 * assumes a 32-bit avalon-mm slave with byte offsets, one word apart.
 */
package asc_pkg;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] SEQ_CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] TEST_OFS = 8'h08;
    localparam logic [7:0] PORT_OFS = 8'h0c;
    localparam logic [7:0] CONFIG_OFS = 8'h10;
    localparam logic [7:0] RESULT_OFS = 8'h20;
    // result_low_byte of slot 0 sits at printed index 0x71
    localparam logic [7:0] RESULT_LOW_IDX = 8'h71;

    // ****************************************************************
    // fields
    // ****************************************************************
    localparam int CTL_SCAN_BIT = 5;
    localparam int CTL_S8_BIT = 6;
    localparam int CTL_MULTICHANNEL_ENABLE_BIT = 4;
    localparam int STAT_SCF_BIT = 15;
    localparam int STAT_CNT_LSB = 8;
    localparam int TEST_RST_BIT = 10;
    localparam int TEST_OUT_BIT = 11;
    localparam int TEST_SEL_LSB = 12;
    localparam int CFG_PU_BIT = 0;
    localparam int CFG_FFC_BIT = 1;
    localparam int CFG_10B_BIT = 2;

    // ****************************************************************
    // reset values and timing
    // ****************************************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] CFG_RST = 3'h0;
    localparam logic [9:0] SAR_RST = 10'h000;
    localparam logic [5:0] CONV_CYC_8B = 6'h12;
    localparam logic [5:0] CONV_CYC_10B = 6'h14;

    typedef enum logic [1:0] {ASC_IDLE, ASC_CONV, ASC_STORE} asc_state_t;

    typedef struct packed {
        logic start;
        logic [3:0] chan;
        logic ten_bit;
    } asc_core_req_t;
endpackage

// file: testbench/asc_chk.sv
/* port checker, bound to the sequencer from tb_top; sees its ports only. */
module asc_chk (input wire logic clk_sys_i, input wire logic rst_i,
    input wire logic special_mode_i, input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i, input wire logic avs_waitrequest_o,
    input wire logic [31:0] avs_readdata_o, input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i, input wire logic [3:0] avs_byteenable_i,
    input wire asc_pkg::asc_core_req_t core_req_o, input wire logic [7:0] digital_pin_levels_i);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    property p_tst; avs_read_i && !avs_waitrequest_o && !special_mode_i
        && avs_address_i == asc_pkg::TEST_OFS |-> avs_readdata_o == 32'h0; endproperty
    a_tst: assert property (p_tst) else $error("test read not zero");
    property p_wait; avs_read_i |-> ##[0:16] !avs_waitrequest_o; endproperty
    a_wait: assert property (p_wait) else $error("read unanswered");
    property p_ack; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_ack: assert property (p_ack) else $error("answer held too long");
    property p_port; avs_read_i && !avs_waitrequest_o && avs_address_i == asc_pkg::PORT_OFS
        |-> avs_readdata_o == {24'h0, $past(digital_pin_levels_i)}; endproperty
    a_port: assert property (p_port) else $error("port read wrong");
    property p_stat; avs_read_i && !avs_waitrequest_o && avs_address_i == asc_pkg::STATUS_OFS
        |-> avs_readdata_o[31:16] == 16'h0 && avs_readdata_o[14:11] == 4'h0; endproperty
    a_stat: assert property (p_stat) else $error("status spare bits set");
    property p_single; avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
        && avs_address_i == asc_pkg::SEQ_CTRL_OFS && !avs_writedata_i[asc_pkg::CTL_MULTICHANNEL_ENABLE_BIT]
        |=> !core_req_o.start || core_req_o.chan == $past(avs_writedata_i[3:0]); endproperty
    a_single: assert property (p_single) else $error("single channel wrong");
    property p_mult8; avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
        && avs_address_i == asc_pkg::SEQ_CTRL_OFS && avs_writedata_i[asc_pkg::CTL_MULTICHANNEL_ENABLE_BIT]
        && avs_writedata_i[asc_pkg::CTL_S8_BIT]
        |=> !core_req_o.start || core_req_o.chan == {$past(avs_writedata_i[3]), 3'h0};
    endproperty
    a_mult8: assert property (p_mult8) else $error("group start wrong");
endmodule // asc_chk

// file: testbench/asc_core_model.sv
/* analog core model: one done pulse five cycles after each start; assumes one-cycle starts. */
module asc_core_model (input wire logic clk_sys_i, input wire logic rst_i,
    input wire logic start_i, output logic done_o);
    timeunit 1ns; timeprecision 1ns;
    logic [2:0] dly_q;
    always_ff @(posedge clk_sys_i) done_o <= dly_q == 3'h1;
    always_ff @(posedge clk_sys_i) dly_q <= rst_i ? 3'h0 : start_i ? 3'h4 : dly_q - 3'(|dly_q);
endmodule // asc_core_model

// file: testbench/tb_top.sv
/* bench top: avalon-mm master, core model, checker bind; normal mode, then special mode. */
module tb_top;
    timeunit 1ns; timeprecision 1ns;
    logic clk_sys_i = 0, rst_i = 1, rd = 0, wr = 0, sm = 0, wt, done;
    logic [7:0] adr = 8'h00; logic [31:0] wd = 32'h0, rdat, q;
    int mismatches = 0, check_count = 0; asc_pkg::asc_core_req_t req;
    always #25 clk_sys_i = ~clk_sys_i;
    asc_adc_sequence_control DUT (.clk_sys_i, .rst_i, .special_mode_i(sm), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .core_req_o(req), .core_done_i(done),
        .core_value_i({req.chan, 6'h2a}), .approximation_value_o(), .test_output_mux_o(),
        .factory_test_select_o(), .digital_pin_levels_i(8'h5a));
    asc_core_model u_core (.clk_sys_i, .rst_i, .start_i(req.start), .done_o(done));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {adr, wd, rd, wr} <= {a, d, !w, w};
        do @(posedge clk_sys_i); while (wt !== 1'b0);
        q = rdat; {rd, wr} <= 2'b00;
        @(posedge clk_sys_i);
    endtask
    task automatic chk(input logic [31:0] g, e);
        check_count++;
        if (g !== e) begin mismatches++; $display("ERROR %0t got %h want %h", $time, g, e); end
    endtask
    task automatic stop_test;
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin #2000000; mismatches++; stop_test; end
    initial begin
        repeat (16) @(posedge clk_sys_i); rst_i <= 1'b0; @(posedge clk_sys_i);
        bus(1'b0, asc_pkg::TEST_OFS, 0); chk(q, 0);
        bus(1'b0, asc_pkg::PORT_OFS, 0); chk(q[7:0], 8'h5a);
        bus(1'b1, asc_pkg::CONFIG_OFS, 32'h1); bus(1'b1, asc_pkg::SEQ_CTRL_OFS, 0);
        q = 0; repeat (60) if (q[15] !== 1'b1) bus(1'b0, asc_pkg::STATUS_OFS, 0);
        chk({q[15], q[3:0]}, 5'h1f);
        bus(1'b1, asc_pkg::SEQ_CTRL_OFS, 0);
        bus(1'b0, asc_pkg::STATUS_OFS, 0); chk({q[15], q[3:0]}, 0);
        bus(1'b1, asc_pkg::SEQ_CTRL_OFS, 32'h58);
        q = 0; repeat (60) if (q[15] !== 1'b1) bus(1'b0, asc_pkg::STATUS_OFS, 0);
        chk({q[15], q[10:8], q[7:0]}, 12'h8ff);
        bus(1'b0, asc_pkg::RESULT_OFS + 8'h10, 0); chk(q[15:0], 16'hca00);
        bus(1'b0, asc_pkg::STATUS_OFS, 0); chk(q[7:0], 8'hef);
        sm <= 1'b1;
        bus(1'b1, asc_pkg::TEST_OFS, 32'h155);
        bus(1'b0, asc_pkg::TEST_OFS, 0); chk(q, 32'h155);
        bus(1'b1, asc_pkg::TEST_OFS, 32'h400);
        bus(1'b0, asc_pkg::SEQ_CTRL_OFS, 0); chk(q[7:0], 8'h00);
        bus(1'b0, asc_pkg::CONFIG_OFS, 0); chk(q[2:0], 3'h1);
        sm <= 1'b0;
        stop_test;
    end
endmodule // tb_top
bind asc_adc_sequence_control asc_chk u_chk (.clk_sys_i, .rst_i, .special_mode_i, .avs_address_i,
    .avs_read_i, .avs_waitrequest_o, .avs_readdata_o, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .core_req_o, .digital_pin_levels_i);
